// *** src/osc_regs_pkg.sv ***
// Purpose: shared constants and types for the oscillator frequency control register bank
// Assumes: 8-bit registers behind an I2C target port, 2-bit page extension
// Notes: reset values are the power-up register contents

package osc_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets (8-bit I2C register address)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_TRIGGER = 8'h07;
  localparam logic [7:0] OFF_HS_DIV_LO = 8'h17;
  localparam logic [7:0] OFF_LS_HS_HI = 8'h18;
  localparam logic [7:0] OFF_FB_FRAC0 = 8'h1a;
  localparam logic [7:0] OFF_FB_FRAC1 = 8'h1b;
  localparam logic [7:0] OFF_FB_FRAC2 = 8'h1c;
  localparam logic [7:0] OFF_FB_FRAC3 = 8'h1d;
  localparam logic [7:0] OFF_FB_INT_LO = 8'h1e;
  localparam logic [7:0] OFF_FB_INT_HI = 8'h1f;
  localparam logic [7:0] OFF_CAL_BYPASS = 8'h45;
  localparam logic [7:0] OFF_FINE_B0 = 8'he7;
  localparam logic [7:0] OFF_FINE_B1 = 8'he8;
  localparam logic [7:0] OFF_FINE_B2 = 8'he9;
  localparam logic [7:0] OFF_PAGE_SEL = 8'hff;
  localparam logic [1:0] PAGE_MAIN = 2'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_CAL_START = 3;
  localparam int BIT_CAL_BYPASS = 7;
  localparam int LS_CODE_LSB = 4;
  localparam logic [6:0] CAL_BYPASS_RSVD = 7'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] RST_HS_DIV = 11'h054;
  localparam logic [2:0] RST_LS_CODE = 3'h0;
  localparam logic [5:0] RST_LS_RATIO = 6'h01;
  localparam logic [42:0] RST_FB_DIV = 43'h064_0000_0000;
  localparam logic RST_CAL_BYPASS = 1'b0;
  localparam logic [23:0] RST_FINE_OFFSET = 24'h00_0000;
  localparam logic [1:0] RST_PAGE = 2'h0;

  // low-speed divider: codes from this one up all divide by the maximum
  localparam logic [2:0] LS_CODE_MAX = 3'h5;
  localparam logic [5:0] LS_RATIO_MAX = 6'h20;
  localparam logic [5:0] LS_RATIO_ONE = 6'h01;

  // ----------------------------------------------------------------
  // I2C target states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV = 7'h02,
    ST_PTR = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_ACK = 7'h20,
    ST_RACK = 7'h40
  } i2c_state_e;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // applied synthesizer configuration
  typedef struct packed {
    logic [10:0] hs_div;
    logic [2:0] ls_code;
    logic [5:0] ls_ratio;
    logic [42:0] fb_div;
    logic cal_bypass;
    logic [23:0] fine_offset;
  } osc_cfg_s;

  localparam osc_cfg_s RST_CFG = '{
    hs_div: RST_HS_DIV,
    ls_code: RST_LS_CODE,
    ls_ratio: RST_LS_RATIO,
    fb_div: RST_FB_DIV,
    cal_bypass: RST_CAL_BYPASS,
    fine_offset: RST_FINE_OFFSET
  };

endpackage

// *** src/osc_freq_ctrl.sv ***
// Purpose: register bank of a programmable oscillator, reached over an I2C target port
// Assumes: scl and sda are synchronous to i_clk and slow against it
// Notes: open-drain sda is split into input, output and output enable

`timescale 1ns/100ps

module osc_freq_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h55  // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output osc_regs_pkg::osc_cfg_s o_cfg,
  output logic o_soft_reset,
  output logic o_cal_start
);
  import osc_regs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  i2c_state_e state_q;
  i2c_state_e ack_next_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic [3:0] cnt_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic wr_q;
  logic [7:0] wdat_q;
  logic [1:0] page_q;
  logic [7:0] fine_b0_q;
  logic [7:0] fine_b1_q;
  logic soft_rst_q;
  logic cal_start_q;
  logic sda_oe_q;
  osc_cfg_s cfg_q;

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire start_cond = scl_q & i_scl & sda_q & ~i_sda;
  wire stop_cond = scl_q & i_scl & ~sda_q & i_sda;
  wire byte_done = scl_fall & (cnt_q == BITS_PER_BYTE);
  wire addr_match = (sr_q[7:1] == DEV_ADDR);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire main_page = (page_q == PAGE_MAIN);
  wire sel_ctrl = main_page & (ptr_q == OFF_CTRL_TRIGGER);
  wire sel_hs_lo = main_page & (ptr_q == OFF_HS_DIV_LO);
  wire sel_ls_hs = main_page & (ptr_q == OFF_LS_HS_HI);
  wire sel_fb0 = main_page & (ptr_q == OFF_FB_FRAC0);
  wire sel_fb1 = main_page & (ptr_q == OFF_FB_FRAC1);
  wire sel_fb2 = main_page & (ptr_q == OFF_FB_FRAC2);
  wire sel_fb3 = main_page & (ptr_q == OFF_FB_FRAC3);
  wire sel_fbi0 = main_page & (ptr_q == OFF_FB_INT_LO);
  wire sel_fbi1 = main_page & (ptr_q == OFF_FB_INT_HI);
  wire sel_byp = main_page & (ptr_q == OFF_CAL_BYPASS);
  wire sel_fine0 = main_page & (ptr_q == OFF_FINE_B0);
  wire sel_fine1 = main_page & (ptr_q == OFF_FINE_B1);
  wire sel_fine2 = main_page & (ptr_q == OFF_FINE_B2);
  // page select stays reachable from every page
  wire sel_page = (ptr_q == OFF_PAGE_SEL);

  wire wr_now = byte_done & (state_q == ST_WDATA);

  wire [2:0] ls_code_w = wdat_q[LS_CODE_LSB +: 3];
  wire [5:0] ls_ratio_w = (ls_code_w >= LS_CODE_MAX) ? LS_RATIO_MAX :
                          6'(LS_RATIO_ONE << ls_code_w);

  wire [7:0] rd_byte =
    sel_hs_lo ? cfg_q.hs_div[7:0] :
    sel_ls_hs ? {1'b0, cfg_q.ls_code, 1'b0, cfg_q.hs_div[10:8]} :
    sel_fb0 ? cfg_q.fb_div[7:0] :
    sel_fb1 ? cfg_q.fb_div[15:8] :
    sel_fb2 ? cfg_q.fb_div[23:16] :
    sel_fb3 ? cfg_q.fb_div[31:24] :
    sel_fbi0 ? cfg_q.fb_div[39:32] :
    sel_fbi1 ? {5'h00, cfg_q.fb_div[42:40]} :
    sel_byp ? {cfg_q.cal_bypass, CAL_BYPASS_RSVD} :
    sel_fine0 ? fine_b0_q :
    sel_fine1 ? fine_b1_q :
    sel_fine2 ? cfg_q.fine_offset[23:16] :
    sel_page ? {6'h00, page_q} :
    8'h00;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (i_ce) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // ----------------------------------------------------------------
  // I2C target sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      ack_next_q <= ST_IDLE;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (i_ce) begin
      if (start_cond) begin
        state_q <= ST_DEV;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        if (scl_rise) begin
          sr_q <= {sr_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
        end
        case (state_q)
          ST_DEV: begin
            if (byte_done) begin
              if (addr_match) begin
                rw_q <= sr_q[0];
                sda_oe_q <= 1'b1;
                state_q <= ST_ACK;
                ack_next_q <= sr_q[0] ? ST_RDATA : ST_PTR;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (byte_done) begin
              ptr_q <= sr_q;
              sda_oe_q <= 1'b1;
              state_q <= ST_ACK;
              ack_next_q <= ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              sda_oe_q <= 1'b1;
              state_q <= ST_ACK;
              ack_next_q <= ST_WDATA;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              state_q <= ack_next_q;
              if (ack_next_q == ST_RDATA) begin
                tx_q <= rd_byte;
                sda_oe_q <= ~rd_byte[7];
              end else begin
                sda_oe_q <= 1'b0;
              end
              if (ack_next_q == ST_WDATA && !rw_q && wr_q) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_RDATA: begin
            if (byte_done) begin
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              cnt_q <= 4'h0;
              state_q <= ST_RACK;
            end else if (scl_fall) begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (sr_q[0]) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_RDATA;
                tx_q <= rd_byte;
                sda_oe_q <= ~rd_byte[7];
              end
            end
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // write strobe: data byte taken at its last bit, applied during ack
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
    end else if (i_ce) begin
      if (wr_now) begin
        wdat_q <= sr_q;
      end
      if (start_cond) begin
        wr_q <= 1'b0;
      end else if (wr_now) begin
        wr_q <= 1'b1;
      end else if (state_q == ST_ACK && scl_fall) begin
        wr_q <= 1'b0;
      end
    end
  end

  // one write per byte: fires on the cycle wr_q rises
  logic wr_seen_q;
  wire wr_en = wr_q & ~wr_seen_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_seen_q <= 1'b0;
    end else if (i_ce) begin
      wr_seen_q <= wr_q;
    end
  end

  // ----------------------------------------------------------------
  // control register: bits act and are never stored
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      soft_rst_q <= 1'b0;
      cal_start_q <= 1'b0;
    end else if (i_ce) begin
      soft_rst_q <= wr_en & sel_ctrl & wdat_q[BIT_SOFT_RESET];
      cal_start_q <= wr_en & sel_ctrl & wdat_q[BIT_CAL_START] & ~cfg_q.cal_bypass;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // soft reset obeys the clock enable like any other update
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_q <= RST_CFG;
      page_q <= RST_PAGE;
      fine_b0_q <= 8'h00;
      fine_b1_q <= 8'h00;
    end else if (i_ce && soft_rst_q) begin
      cfg_q <= RST_CFG;
      page_q <= RST_PAGE;
      fine_b0_q <= 8'h00;
      fine_b1_q <= 8'h00;
    end else if (i_ce && wr_en) begin
      if (sel_hs_lo) begin
        cfg_q.hs_div[7:0] <= wdat_q;
      end else if (sel_ls_hs) begin
        cfg_q.hs_div[10:8] <= wdat_q[2:0];
        cfg_q.ls_code <= ls_code_w;
        cfg_q.ls_ratio <= ls_ratio_w;
      end else if (sel_fb0) begin
        cfg_q.fb_div[7:0] <= wdat_q;
      end else if (sel_fb1) begin
        cfg_q.fb_div[15:8] <= wdat_q;
      end else if (sel_fb2) begin
        cfg_q.fb_div[23:16] <= wdat_q;
      end else if (sel_fb3) begin
        cfg_q.fb_div[31:24] <= wdat_q;
      end else if (sel_fbi0) begin
        cfg_q.fb_div[39:32] <= wdat_q;
      end else if (sel_fbi1) begin
        cfg_q.fb_div[42:40] <= wdat_q[2:0];
      end else if (sel_byp) begin
        cfg_q.cal_bypass <= wdat_q[BIT_CAL_BYPASS];
      end else if (sel_fine0) begin
        fine_b0_q <= wdat_q;
      end else if (sel_fine1) begin
        fine_b1_q <= wdat_q;
      end else if (sel_fine2) begin
        cfg_q.fine_offset <= {wdat_q, fine_b1_q, fine_b0_q};
      end else if (sel_page) begin
        page_q <= wdat_q[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_cfg <= RST_CFG;
      o_soft_reset <= 1'b0;
      o_cal_start <= 1'b0;
    end else if (i_ce) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= sda_oe_q;
      o_cfg <= cfg_q;
      o_soft_reset <= soft_rst_q;
      o_cal_start <= cal_start_q;
    end
  end

endmodule

// *** verification/osc_freq_ctrl_monitor.sv ***
// Purpose: port checker for the oscillator register bank
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind below the module

`timescale 1ns/100ps

module osc_freq_ctrl_monitor #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire osc_regs_pkg::osc_cfg_s o_cfg,
  input wire logic o_soft_reset,
  input wire logic o_cal_start
);
  import osc_regs_pkg::*;
  // ----
  // sequences and checks
  // ----
  sequence s_scl_high2;
    i_scl ##1 i_scl;
  endsequence

  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_sda_never_high: assert property (@(posedge i_clk) disable iff (i_srst) !o_sda_out)
    else $error("sda output level not low");
  a_reset_state: assert property (@(posedge i_clk) i_srst |=> (o_cfg == RST_CFG) && !o_sda_oe
    && !o_soft_reset && !o_cal_start) else $error("outputs not at reset state");
  a_soft_reset_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    o_soft_reset |-> s_pulse(o_soft_reset)) else $error("soft reset pulse too long");
  a_soft_reset_clears: assert property (@(posedge i_clk) disable iff (i_srst)
    o_soft_reset |-> ##[0:3] (o_cfg == RST_CFG)) else $error("soft reset left config");
  a_cal_start_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cal_start |-> s_pulse(o_cal_start)) else $error("calibration pulse too long");
  a_cal_bypass_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cal_start |-> !o_cfg.cal_bypass) else $error("calibration started while bypassed");
  a_ls_ratio_table: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cfg.ls_ratio == ((o_cfg.ls_code > 3'h4) ? 6'h20 : 6'(6'h01 << o_cfg.ls_code)))
    else $error("low-speed ratio wrong");
  a_ls_bypass_one: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_cfg.ls_code == 3'h0) |-> (o_cfg.ls_ratio == 6'h01)) else $error("code zero not divide by one");
  a_oe_steady_high: assert property (@(posedge i_clk) disable iff (i_srst)
    s_scl_high2 |-> $stable(o_sda_oe)) else $error("sda drive moved while scl high");
  a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_ce |=> $stable(o_cfg) && $stable(o_sda_oe)) else $error("outputs moved while clock enable low");
endmodule

bind osc_freq_ctrl osc_freq_ctrl_monitor #(.DEV_ADDR(DEV_ADDR)) i_osc_freq_ctrl_monitor (
  .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_cfg(o_cfg),
  .o_soft_reset(o_soft_reset), .o_cal_start(o_cal_start));

// *** verification/i2c_host_model.sv ***
// Purpose: I2C host model for the register bank's target port
// Assumes: scl phases of at least four clocks, sda pulled up
// Notes: byte tasks are called by the testbench

`timescale 1ns/100ps

module i2c_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ----
  // bus phases
  // ----
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic hold();
    repeat (4) @(posedge i_clk);
  endtask

  task automatic start();
    hold();
    o_sda <= 1'b1;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda <= 1'b0;
    hold();
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    hold();
    o_sda <= 1'b0;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda <= 1'b1;
    hold();
  endtask

  // sda moves only while scl is low; sampled at the end of the high phase
  task automatic clock_bit(input logic b, output logic seen);
    hold();
    o_sda <= b;
    hold();
    o_scl <= 1'b1;
    hold();
    seen = i_sda;
    o_scl <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(last, s);
  endtask
endmodule

// *** verification/oscillator_freq_control_regs_test.sv ***
// Purpose: self-checking bench for the oscillator register bank
// Assumes: host model drives scl and sda, device pulls sda low
// Notes: clock enable dropped once while the bus is idle

`timescale 1ns/100ps

module oscillator_freq_control_regs_test;
  import osc_regs_pkg::*;
  localparam logic [6:0] DEV = 7'h55;
  logic i_clk;
  logic i_srst = 1'b1;
  logic ce = 1'b1;
  logic scl, host_sda, sda_oe, soft_reset, cal_start;
  osc_cfg_s cfg;
  wire sda = host_sda & ~sda_oe;
  int errors, n_checks, n_soft, n_cal;
  logic [7:0] rq[$];
  logic a;

  osc_freq_ctrl #(.DEV_ADDR(DEV)) i_osc_freq_ctrl (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce),
    .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe), .o_cfg(cfg),
    .o_soft_reset(soft_reset), .o_cal_start(cal_start));
  i2c_host_model i_i2c_host_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));

  // ----
  // tasks
  // ----
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (soft_reset === 1'b1) n_soft++;
    if (cal_start === 1'b1) n_cal++;
  end

  task automatic check(input logic [87:0] seen, input logic [87:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    logic k;
    i_i2c_host_model.put_byte(b, k);
    check(k, 1'b1);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data[$]);
    i_i2c_host_model.start();
    send({DEV, 1'b0});
    send(addr);
    foreach (data[i]) send(data[i]);
    i_i2c_host_model.stop();
  endtask

  task automatic rd(input logic [7:0] addr, input int n);
    logic [7:0] d;
    rq.delete();
    i_i2c_host_model.start();
    send({DEV, 1'b0});
    send(addr);
    i_i2c_host_model.start();
    send({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      i_i2c_host_model.get_byte(i == n - 1, d);
      rq.push_back(d);
    end
    i_i2c_host_model.stop();
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    check(cfg, RST_CFG);
    wr(OFF_HS_DIV_LO, '{8'h9a, 8'h35});
    check(cfg.hs_div, 11'h59a);
    check(cfg.ls_code, 3'h3);
    rd(OFF_HS_DIV_LO, 2);
    check(rq[0], 8'h9a);
    check(rq[1], 8'h35);
    for (int c = 0; c < 8; c++) begin
      wr(OFF_LS_HS_HI, '{{1'b0, 3'(c), 4'h0}});
      check(cfg.ls_ratio, (c > 4) ? 6'h20 : 6'(6'h01 << c));
    end
    check(cfg.hs_div, 11'h09a);
    $display("test dividers done");
    wr(OFF_FB_FRAC0, '{8'h34, 8'h79, 8'h38, 8'ha8, 8'hc5, 8'h00});
    check(cfg.fb_div, 43'h0c5_a838_7934);
    rd(OFF_FB_FRAC0, 6);
    check(rq[0], 8'h34);
    check(rq[4], 8'hc5);
    $display("test feedback done");
    wr(OFF_CAL_BYPASS, '{8'h80});
    check(cfg.cal_bypass, 1'b1);
    wr(OFF_CTRL_TRIGGER, '{8'h08});
    check(n_cal, 0);
    rd(OFF_CAL_BYPASS, 1);
    check(rq[0], 8'h81);
    wr(OFF_CAL_BYPASS, '{8'h00});
    wr(OFF_CTRL_TRIGGER, '{8'h08});
    check(n_cal, 1);
    rd(OFF_CTRL_TRIGGER, 1);
    check(rq[0], 8'h00);
    $display("test calibration done");
    wr(OFF_FINE_B0, '{8'h11});
    wr(OFF_FINE_B1, '{8'h22});
    check(cfg.fine_offset, 24'h00_0000);
    wr(OFF_FINE_B2, '{8'hff});
    check(cfg.fine_offset, 24'hff_2211);
    rd(OFF_FINE_B0, 3);
    check(rq[0], 8'h11);
    check(rq[2], 8'hff);
    wr(OFF_FINE_B0, '{8'h33});
    ce <= 1'b0;
    repeat (8) @(posedge i_clk);
    ce <= 1'b1;
    check(cfg.fine_offset, 24'hff_2211);
    $display("test fine offset done");
    wr(OFF_PAGE_SEL, '{8'h01});
    wr(OFF_HS_DIV_LO, '{8'h05});
    check(cfg.hs_div, 11'h09a);
    rd(OFF_HS_DIV_LO, 1);
    check(rq[0], 8'h00);
    wr(OFF_PAGE_SEL, '{8'h00});
    rd(8'h50, 1);
    check(rq[0], 8'h00);
    i_i2c_host_model.start();
    i_i2c_host_model.put_byte({7'h2a, 1'b0}, a);
    i_i2c_host_model.stop();
    check(a, 1'b0);
    $display("test paging done");
    wr(OFF_CTRL_TRIGGER, '{8'h80});
    check(n_soft, 1);
    check(cfg, RST_CFG);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
